// File: exec_pkg.sv
// Constants shared by the swap, test and long-multiply execution logic.
// Assumes a 32-bit instruction word and a 100 MHz core clock.
package exec_pkg;
    // Instruction field positions.
    localparam int COND_HI     = 31;
    localparam int COND_LO     = 28;
    localparam int IMM_BIT     = 25;
    localparam int BYTE_BIT    = 22;
    localparam int ACC_BIT     = 21;
    localparam int SET_BIT     = 20;
    // Decode patterns.
    localparam logic [4:0] SWAP_OP  = 5'h02;
    localparam logic [4:0] MULL_OP  = 5'h01;
    localparam logic [4:0] TEQ_OP   = 5'h13;
    localparam logic [4:0] TST_OP   = 5'h11;
    localparam logic [3:0] MUL_MARK = 4'h9;
    // Flag positions in the 4-bit flag vector {N,Z,C,V}.
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    // Register bus map (word byte addresses).
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ    = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hC;
    // Reset values and event bit positions.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0]  MASK_RESET = 3'h0;
    localparam int EV_DONE  = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_ALIGN = 2;
    // Multiplier: one cycle per active byte of the second multiplicand.
    localparam logic [2:0] MUL_STEPS = 3'h4;
    // Machine states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_STORE = 3'b010,
        ST_MUL   = 3'b011,
        ST_DONE  = 3'b100
    } state_t;
endpackage

// File: cond_check.sv
// Condition field evaluator against the current flags.
// Assumes flags are given as {N,Z,C,V}.
`timescale 1ns/1ns
module cond_check
    import exec_pkg::*;
(
    // Inputs.
    input  wire logic [3:0] cond_i,
    input  wire logic [3:0] flags_i,
    // Result.
    output logic            pass_o
);
    logic n, z, c, v;
    assign n = flags_i[FLAG_N];
    assign z = flags_i[FLAG_Z];
    assign c = flags_i[FLAG_C];
    assign v = flags_i[FLAG_V];

    // Evaluates the sixteen condition codes; code 15 never passes.
    always_comb begin
        case (cond_i)
            4'h0: pass_o = z;
            4'h1: pass_o = !z;
            4'h2: pass_o = c;
            4'h3: pass_o = !c;
            4'h4: pass_o = n;
            4'h5: pass_o = !n;
            4'h6: pass_o = v;
            4'h7: pass_o = !v;
            4'h8: pass_o = c && !z;
            4'h9: pass_o = !c || z;
            4'hA: pass_o = n == v;
            4'hB: pass_o = n != v;
            4'hC: pass_o = !z && (n == v);
            4'hD: pass_o = z || (n != v);
            4'hE: pass_o = 1'b1;
            default: pass_o = 1'b0;
        endcase
    end
endmodule

// File: mul_long.sv
// Unsigned 32x32 multiplier, eight multiplicand bits a cycle,
// stopping early once the upper bytes are zero.
// Assumes start_i pulses only while the unit is idle.
`timescale 1ns/1ns
module mul_long
    import exec_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Operands.
    input  wire logic        start_i,
    input  wire logic [31:0] a_i,
    input  wire logic [31:0] b_i,
    // Result.
    output logic             done_o,
    output logic [63:0]      prod_o
);
    logic [31:0] a_r;
    logic [31:0] b_r;
    logic [2:0]  step_r;
    logic        busy_r;
    logic [39:0] part;

    assign part = a_r * b_r[7:0];

    // Shift-and-add, stopping when remaining multiplicand bits are zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_r    <= 32'h0000_0000;
            b_r    <= 32'h0000_0000;
            step_r <= 3'h0;
            busy_r <= 1'b0;
            done_o <= 1'b0;
            prod_o <= 64'h0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                a_r    <= a_i;
                b_r    <= b_i;
                step_r <= 3'h0;
                busy_r <= 1'b1;
                prod_o <= 64'h0;
            end else if (busy_r) begin
                prod_o <= prod_o + ({24'h0, part} << (8 * step_r));
                b_r    <= b_r >> 8;
                step_r <= step_r + 3'h1;
                // Unsigned early stop judged on the second multiplicand.
                if (b_r[31:8] == 24'h0 || step_r == MUL_STEPS - 3'h1) begin
                    busy_r <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule

// File: exec_unit.sv
// Execution unit for word and byte swap, test equivalence, bit test and
// unsigned long multiply with optional accumulation.
// Assumes the register file answers reads combinationally and the memory
// port holds req until ack or abort; a Wishbone slave gives control and
// event status.
// Operation
// - Execute only when condition passes.
// - Word swap: load, store source, write loaded.
// - Rotate misaligned loaded word by address.
// - Abort on either access blocks destination write.
// - Alignment check raises exception on misaligned word.
// - Byte swap zero-extends loaded byte.
// - Swap decode pattern; bit 22 selects byte.
// - Test equivalence: XOR sets N and Z.
// - Test equivalence: carry from shifter, V kept.
// - Test equivalence decode pattern.
// - Bit test: AND updates flags only.
// - Bit test decode pattern.
// - Accumulate: low add carries into high.
// - Long multiply writes high and low halves.
// - Set-flags: N from high, Z both zero.
// - Long multiply decode; bit 21 accumulates.
// - Early termination judged on second multiplicand.
`timescale 1ns/1ns
module exec_unit
    import exec_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Instruction issue.
    input  wire logic        issue_i,
    input  wire logic [31:0] instr_i,
    input  wire logic [31:0] shifter_op_i,
    input  wire logic        shifter_carry_i,
    output logic             busy_o,
    // Register file reads and write.
    output logic [3:0]       rd_a_idx_o,
    output logic [3:0]       rd_b_idx_o,
    output logic [3:0]       rd_c_idx_o,
    output logic [3:0]       rd_d_idx_o,
    input  wire logic [31:0] rd_a_i,
    input  wire logic [31:0] rd_b_i,
    input  wire logic [31:0] rd_c_i,
    input  wire logic [31:0] rd_d_i,
    output logic             wr_en_o,
    output logic [3:0]       wr_idx_o,
    output logic [31:0]      wr_data_o,
    output logic             wr2_en_o,
    output logic [3:0]       wr2_idx_o,
    output logic [31:0]      wr2_data_o,
    // Condition flags {N,Z,C,V}.
    output logic [3:0]       flags_o,
    // Memory port.
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic             mem_byte_o,
    output logic             mem_lock_o,
    output logic [31:0]      mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic        mem_abort_i,
    input  wire logic [31:0] mem_rdata_i,
    output logic             align_exc_o,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o
);
    state_t      state_r;
    logic [31:0] ir_r;
    logic [31:0] addr_r;
    logic [31:0] src_r;
    logic [31:0] load_r;
    logic        abort_r;
    logic [31:0] ctrl_r;
    logic [2:0]  ev_r;
    logic [2:0]  mask_r;
    logic [2:0]  ev_set;
    logic        pass;
    logic        mul_start;
    logic        mul_done;
    logic [63:0] prod;
    logic [32:0] lo_sum;
    logic [31:0] hi_res;
    logic [31:0] lo_res;
    logic [31:0] logic_res;
    logic        wb_hit;
    logic        wb_wr;
    logic        misalign;

    // Decoders of the instruction classes.
    function automatic logic is_swap(input logic [31:0] i);
        return i[27:23] == SWAP_OP && i[21:20] == 2'b00
            && i[7:4] == MUL_MARK;
    endfunction
    function automatic logic is_mull(input logic [31:0] i);
        return i[27:23] == MULL_OP && !i[BYTE_BIT]
            && i[7:4] == MUL_MARK;
    endfunction
    function automatic logic is_teq(input logic [31:0] i);
        return i[27:26] == 2'b00 && i[24:20] == TEQ_OP
            && !(i[IMM_BIT] == 1'b0 && i[7] && i[4]);
    endfunction
    function automatic logic is_tst(input logic [31:0] i);
        return i[27:26] == 2'b00 && i[24:20] == TST_OP
            && !(i[IMM_BIT] == 1'b0 && i[7] && i[4]);
    endfunction

    cond_check u_cond (
        .cond_i  (instr_i[COND_HI:COND_LO]),
        .flags_i (flags_o),
        .pass_o  (pass)
    );

    mul_long u_mul (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (mul_start),
        .a_i     (rd_d_i),
        .b_i     (rd_c_i),
        .done_o  (mul_done),
        .prod_o  (prod)
    );

    // Operand read ports: base/first source, source, second multiplicand,
    // and for multiplies the accumulating destinations.
    assign rd_a_idx_o = instr_i[19:16];
    assign rd_b_idx_o = instr_i[15:12];
    assign rd_c_idx_o = instr_i[11:8];
    assign rd_d_idx_o = instr_i[3:0];

    assign mul_start = issue_i && state_r == ST_IDLE && pass
                     && is_mull(instr_i);
    assign logic_res = instr_i[21] ? rd_a_i ^ shifter_op_i
                                   : rd_a_i & shifter_op_i;
    assign misalign  = ctrl_r[0] && !instr_i[BYTE_BIT] && rd_a_i[1:0] != 2'h0;

    // Accumulation carries the low-half carry into the high half.
    assign lo_sum = {1'b0, prod[31:0]}
                  + (ir_r[ACC_BIT] ? {1'b0, src_r} : 33'h0);
    assign lo_res = lo_sum[31:0];
    assign hi_res = prod[63:32] + (ir_r[ACC_BIT] ? addr_r : 32'h0)
                  + {31'h0, lo_sum[32]};

    assign ev_set[EV_DONE]  = state_r == ST_DONE;
    assign ev_set[EV_ABORT] = (state_r == ST_LOAD || state_r == ST_STORE)
                            && mem_abort_i;
    assign ev_set[EV_ALIGN] = align_exc_o;

    // Sequencer for swaps and multiplies; flag-only ops finish at issue.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            ir_r    <= 32'h0000_0000;
            addr_r  <= 32'h0000_0000;
            src_r   <= 32'h0000_0000;
            load_r  <= 32'h0000_0000;
            abort_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (issue_i && pass) begin
                        ir_r    <= instr_i;
                        abort_r <= 1'b0;
                        if (is_swap(instr_i)) begin
                            addr_r <= rd_a_i;
                            src_r  <= rd_d_i;
                            if (!misalign) begin
                                state_r <= ST_LOAD;
                            end
                        end else if (is_mull(instr_i)) begin
                            addr_r  <= rd_a_i; // High destination.
                            src_r   <= rd_b_i; // Low destination.
                            state_r <= ST_MUL;
                        end
                    end
                end
                ST_LOAD: begin
                    if (mem_ack_i || mem_abort_i) begin
                        load_r  <= mem_rdata_i;
                        abort_r <= mem_abort_i;
                        state_r <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (mem_ack_i || mem_abort_i) begin
                        abort_r <= abort_r || mem_abort_i;
                        state_r <= ST_DONE;
                    end
                end
                ST_MUL: begin
                    if (mul_done) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Memory port with lock across the load and store of a swap.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_byte_o  <= 1'b0;
            mem_lock_o  <= 1'b0;
            mem_addr_o  <= 32'h0000_0000;
            mem_wdata_o <= 32'h0000_0000;
        end else begin
            if (state_r == ST_IDLE && issue_i && pass && is_swap(instr_i)
                && !misalign) begin
                mem_req_o  <= 1'b1;
                mem_we_o   <= 1'b0;
                mem_lock_o <= 1'b1;
                mem_byte_o <= instr_i[BYTE_BIT];
                mem_addr_o <= rd_a_i;
            end else if (state_r == ST_LOAD
                         && (mem_ack_i || mem_abort_i)) begin
                mem_we_o    <= 1'b1;
                mem_wdata_o <= mem_byte_o ? {24'h0, src_r[7:0]}
                                          : src_r;
            end else if (state_r == ST_STORE
                         && (mem_ack_i || mem_abort_i)) begin
                mem_req_o  <= 1'b0;
                mem_we_o   <= 1'b0;
                mem_lock_o <= 1'b0;
            end
        end
    end

    // Destination writes for swaps and long multiplies.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_en_o    <= 1'b0;
            wr_idx_o   <= 4'h0;
            wr_data_o  <= 32'h0000_0000;
            wr2_en_o   <= 1'b0;
            wr2_idx_o  <= 4'h0;
            wr2_data_o <= 32'h0000_0000;
        end else begin
            wr_en_o  <= 1'b0;
            wr2_en_o <= 1'b0;
            if (state_r == ST_STORE && (mem_ack_i || mem_abort_i)) begin
                wr_en_o  <= !(abort_r || mem_abort_i);
                wr_idx_o <= ir_r[15:12];
                if (mem_byte_o) begin
                    wr_data_o <= {24'h0, load_r[7:0]};
                end else begin
                    wr_data_o <= (load_r >> (8 * addr_r[1:0]))
                               | (load_r << (32 - 8 * addr_r[1:0]));
                end
            end else if (state_r == ST_MUL && mul_done) begin
                wr_en_o    <= 1'b1;
                wr_idx_o   <= ir_r[19:16];
                wr_data_o  <= hi_res;
                wr2_en_o   <= 1'b1;
                wr2_idx_o  <= ir_r[15:12];
                wr2_data_o <= lo_res;
            end
        end
    end

    // Condition flags for the test and long multiply forms.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= 4'h0;
        end else if (state_r == ST_IDLE && issue_i && pass
                     && (is_teq(instr_i) || is_tst(instr_i))) begin
            flags_o[FLAG_N] <= logic_res[31];
            flags_o[FLAG_Z] <= logic_res == 32'h0;
            flags_o[FLAG_C] <= shifter_carry_i;
        end else if (state_r == ST_MUL && mul_done && ir_r[SET_BIT]) begin
            flags_o[FLAG_N] <= hi_res[31];
            flags_o[FLAG_Z] <= hi_res == 32'h0 && lo_res == 32'h0;
        end
    end

    // Alignment exception pulse and busy indication.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            align_exc_o <= 1'b0;
            busy_o      <= 1'b0;
        end else begin
            align_exc_o <= state_r == ST_IDLE && issue_i && pass
                         && is_swap(instr_i) && misalign;
            busy_o <= state_r != ST_IDLE || (issue_i && pass
                      && (is_swap(instr_i) || is_mull(instr_i)));
        end
    end

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0];

    // Control, events and mask; an event beats a clearing write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
            ev_r   <= 3'h0;
            mask_r <= MASK_RESET;
        end else begin
            if (wb_wr && wb_adr_i == ADDR_CTRL) begin
                ctrl_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_wr && wb_adr_i == ADDR_MASK) begin
                mask_r <= wb_dat_i[2:0];
            end
            if (wb_wr && wb_adr_i == ADDR_IRQ) begin
                ev_r <= (ev_r & ~wb_dat_i[2:0]) | ev_set;
            end else begin
                ev_r <= ev_r | ev_set;
            end
        end
    end

    // Wishbone answer one cycle after the strobe, and interrupt line.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o    <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
            irq_o    <= |(ev_r & mask_r);
            case (wb_adr_i)
                ADDR_CTRL:   wb_dat_o <= ctrl_r;
                ADDR_STATUS: wb_dat_o <= {24'h0, flags_o, 1'b0, state_r};
                ADDR_IRQ:    wb_dat_o <= {29'h0, ev_r};
                ADDR_MASK:   wb_dat_o <= {29'h0, mask_r};
                default:     wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// File: exec_unit_props.sv
// Checker for the swap, test and long-multiply execution unit.
// Assumes it is bound into exec_unit and sees only that module's ports.
`timescale 1ns/1ns
module exec_unit_props
    import exec_pkg::*;
(
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Issue side.
    input wire logic        issue_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] shifter_op_i,
    input wire logic        shifter_carry_i,
    input wire logic        busy_o,
    input wire logic [31:0] rd_a_i,
    input wire logic [3:0]  flags_o,
    input wire logic        wr_en_o,
    input wire logic        wr2_en_o,
    // Memory side.
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic        mem_lock_o,
    input wire logic        mem_ack_i,
    input wire logic        mem_abort_i,
    input wire logic        align_exc_o,
    // Register bus.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    logic        go;
    logic        tst_go;
    logic        mul_go;
    logic        skip;
    logic [31:0] res;
    logic [3:0]  exp_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Issues taken always, and issues skipped.
    assign go = issue_i && !busy_o && instr_i[31:28] == 4'hE;
    assign tst_go = go && instr_i[27:26] == 2'h0 &&
                    (instr_i[24:20] == TEQ_OP || instr_i[24:20] == TST_OP);
    assign mul_go = go && instr_i[27:23] == MULL_OP && !instr_i[22] &&
                    instr_i[7:4] == MUL_MARK;
    assign skip = issue_i && !busy_o && instr_i[31:28] == 4'h1 &&
                  flags_o[FLAG_Z];
    assign res = instr_i[21] ? rd_a_i ^ shifter_op_i : rd_a_i & shifter_op_i;
    // Expected flags of a taken test.
    always_ff @(posedge clk_i) begin
        if (tst_go) begin
            exp_r <= {res[31], res == 32'h0, shifter_carry_i,
                      flags_o[FLAG_V]};
        end
    end
    // Locked load and store phases of a swap.
    sequence s_load;
        mem_req_o && !mem_we_o && mem_lock_o;
    endsequence
    sequence s_store;
        mem_req_o && mem_we_o && mem_lock_o;
    endsequence
    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("bus ack late");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    a_test_flags: assert property (
        tst_go |-> ##[1:2] flags_o == exp_r) else $error("test flags wrong");
    a_cond_skip: assert property (
        skip |=> (!busy_o && !mem_req_o && $stable(flags_o)) [*3])
        else $error("failed condition executed");
    a_load_first: assert property (
        $rose(mem_req_o) |-> s_load) else $error("swap not load first");
    a_store_next: assert property (
        s_load ##0 mem_ack_i |-> ##1 s_store)
        else $error("store not after load");
    a_abort_nowr: assert property (
        mem_req_o && mem_abort_i |=> !wr_en_o [*8])
        else $error("write after abort");
    a_align_noacc: assert property (
        align_exc_o |-> !mem_req_o && $past(rd_a_i[1:0]) != 2'h0 &&
        !$past(instr_i[22])) else $error("bad alignment fault");
    a_mul_time: assert property (
        mul_go |-> ##[1:10] wr2_en_o) else $error("multiply too slow");
    a_mul_pair: assert property (wr2_en_o |-> wr_en_o)
        else $error("halves not written together");
endmodule

// File: mem_model.sv
// Memory model holding one word for swap loads and stores.
// Assumes req is held until ack or abort.
`timescale 1ns/1ns
module mem_model #(
    parameter logic [31:0] INIT = 32'h1234_5678
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Request side.
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic        byte_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        abort_on_i,
    // Answer side.
    output logic             ack_o,
    output logic             abort_o,
    output logic [31:0]      rdata_o
);
    logic [31:0] mem_r;
    logic [1:0]  wait_r;
    // Answers after three cycles; read data toggles outside the answer.
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        abort_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (rst_i) begin
            mem_r <= INIT;
            wait_r <= 2'h0;
            rdata_o <= 32'h0;
        end else if (req_i && !ack_o && !abort_o) begin
            wait_r <= wait_r + 2'h1;
            if (wait_r == 2'h2) begin
                wait_r <= 2'h0;
                ack_o <= !abort_on_i;
                abort_o <= abort_on_i;
                rdata_o <= byte_i ? {24'hA5A5A5, mem_r[7:0]} : mem_r;
                if (we_i && !abort_on_i && byte_i) mem_r[7:0] <= wdata_i[7:0];
                else if (we_i && !abort_on_i) mem_r <= wdata_i;
            end
        end
    end
endmodule

// File: exec_unit_bench.sv
// Self-checking bench for the execution unit.
// Assumes mem_model as memory and the checker bound below.
`timescale 1ns/1ns
module exec_unit_bench
    import exec_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0;
    logic        shifter_carry_i, abort_on = 1'b0;
    logic [31:0] instr_i, shifter_op_i, rd_a_i, rd_b_i, rd_c_i, rd_d_i;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        busy_o, wr_en_o, wr2_en_o, mem_req_o, mem_we_o, mem_byte_o;
    logic        mem_lock_o, mem_ack_i, mem_abort_i, align_exc_o;
    logic        wb_ack_o, irq_o;
    logic [3:0]  wr_idx_o, wr2_idx_o, flags_o, ef;
    logic [31:0] wr_data_o, wr2_data_o, mem_wdata_o, mem_rdata_i, wb_dat_o;
    logic [31:0] wd, wd2, rdv, mem_addr_o;
    int          failures = 0, cmp_count = 0, wr_n, al_n, req_n;
    // Free-running core clock.
    always #5 clk_i = ~clk_i;
    exec_unit i_exec_unit (.rd_a_idx_o(), .rd_b_idx_o(), .rd_c_idx_o(),
        .rd_d_idx_o(), .*);
    mem_model i_mem_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o),
        .we_i(mem_we_o), .byte_i(mem_byte_o), .wdata_i(mem_wdata_o),
        .abort_on_i(abort_on), .ack_o(mem_ack_i), .abort_o(mem_abort_i),
        .rdata_o(mem_rdata_i));
    // Records writes, alignment faults and requests.
    always @(posedge clk_i) begin
        if (wr_en_o === 1'b1) begin
            wr_n++;
            wd = wr_data_o;
        end
        if (wr2_en_o === 1'b1) wd2 = wr2_data_o;
        if (align_exc_o === 1'b1) al_n++;
        if (mem_req_o === 1'b1) req_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k >= 40) begin
            failures++;
            end_of_test();
        end
    endtask
    // One classic bus cycle; read data lands in rdv.
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        tmo(k);
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Issues one instruction and waits until idle.
    task automatic run(input logic [31:0] ins, a, b, c, d);
        int k;
        @(posedge clk_i);
        wr_n = 0;
        al_n = 0;
        req_n = 0;
        instr_i <= ins;
        rd_a_i <= a;
        rd_b_i <= b;
        rd_c_i <= c;
        rd_d_i <= d;
        issue_i <= 1'b1;
        @(posedge clk_i);
        issue_i <= 1'b0;
        @(posedge clk_i);
        for (k = 0; k < 40 && busy_o !== 1'b0; k++) @(posedge clk_i);
        tmo(k);
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [31:0] dp(logic [3:0] c, logic i, logic [4:0] o);
        return {c, 2'b00, i, o, 4'h1, 4'h0, 12'h000};
    endfunction
    function automatic logic [31:0] sw(logic [3:0] c, logic b);
        return {c, SWAP_OP, b, 2'b00, 4'h1, 4'h2, 4'h0, MUL_MARK, 4'h3};
    endfunction
    // Flag-only test; the carry in is the expected C flag.
    task automatic tf(input logic i, input logic [4:0] o,
                      input logic [31:0] a, op, input logic [3:0] e);
        shifter_op_i <= op;
        shifter_carry_i <= e[FLAG_C];
        run(dp(4'hE, i, o), a, 0, 0, 0);
        chk({28'h0, flags_o}, {28'h0, e});
    endtask
    // Register read compared with its expected value.
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic mul(input logic acc, input logic [31:0] hi, lo, m, s);
        logic [63:0] p;
        p = {32'h0, m} * {32'h0, s} + (acc ? {hi, lo} : 64'h0);
        run({4'hE, MULL_OP, 1'b0, acc, 1'b1, 16'h2349, 4'h5}, hi, lo, s, m);
        ef = {p[63], p == 64'h0, ef[1:0]};
        chk(wd, p[63:32]);
        chk(wd2, p[31:0]);
        chk({28'h0, flags_o}, {28'h0, ef});
        chk({24'h0, wr_idx_o, wr2_idx_o}, 32'h23);
    endtask
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_MASK, {29'h0, MASK_RESET});
        rd(4'h1, 32'h0);
        tf(1'b0, TEQ_OP, 32'h800000F0, 32'hF0, 4'hA);
        tf(1'b1, TEQ_OP, 32'h1234, 32'h1234, 4'h4);
        tf(1'b0, TST_OP, 32'hF0, 32'hF, 4'h6);
        tf(1'b1, TST_OP, 32'h80000001, 32'h80000000, 4'h8);
        ef = 4'h8;
        mul(1'b0, 0, 0, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        mul(1'b0, 0, 0, 32'h8000_0000, 32'h3);
        mul(1'b1, 32'h1, 32'hFFFF_FFFF, 32'h2, 32'h1);
        mul(1'b0, 0, 0, 32'h5, 32'h0);
        run(sw(4'h1, 1'b0), 32'h100, 0, 0, 32'h5555_5555);
        chk(req_n + wr_n, 0);
        run(sw(4'hE, 1'b0), 32'h100, 0, 0, 32'hCAFE_F00D);
        chk(wd, 32'h1234_5678);
        chk(mem_addr_o, 32'h100);
        chk(i_mem_model.mem_r, 32'hCAFE_F00D);
        run(sw(4'hE, 1'b0), 32'h101, 0, 0, 32'h1111_2222);
        chk(wd, 32'h0DCA_FEF0);
        run(sw(4'hE, 1'b1), 32'h102, 0, 0, 32'h3333_4477);
        chk(wd, 32'h0000_0022);
        chk(i_mem_model.mem_r, 32'h1111_2277);
        abort_on <= 1'b1;
        run(sw(4'hE, 1'b0), 32'h100, 0, 0, 32'h0);
        chk(wr_n, 0);
        abort_on <= 1'b0;
        rd(ADDR_IRQ, 32'h3);
        wb(1'b1, ADDR_MASK, 32'h2);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, ADDR_IRQ, 32'h7);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h1);
        run(sw(4'hE, 1'b0), 32'h101, 0, 0, 32'h0);
        chk(al_n * 2 + req_n + wr_n, 2);
        rd(ADDR_IRQ, 32'h4);
        end_of_test();
    end
endmodule
bind exec_unit exec_unit_props i_exec_unit_props (.*);
